/* core/rtdt_pkg.sv */
// Shared constants and fixed screen formats for the raster text display timing block
`default_nettype none
package rtdt_pkg;
	localparam int RTDT_ADDR_W = 14;
	localparam int RTDT_SCAN_W = 5;
	localparam int RTDT_IDX_W = 5;
	localparam int RTDT_DATA_W = 8;
	localparam int RTDT_HI_W = 6;
	localparam int RTDT_PIN_W = 15;

	// ----------------------------------------
	// Index values of the writable data registers
	// ----------------------------------------
	localparam logic [4:0] RTDT_IDX_START_HI = 5'h0C;
	localparam logic [4:0] RTDT_IDX_START_LO = 5'h0D;
	localparam logic [4:0] RTDT_IDX_CURSOR_HI = 5'h0E;
	localparam logic [4:0] RTDT_IDX_CURSOR_LO = 5'h0F;

	// ----------------------------------------
	// Scan mode encodings and sync width coding
	// ----------------------------------------
	localparam logic [1:0] RTDT_IL_SYNC = 2'h1;
	localparam logic [1:0] RTDT_IL_VIDEO = 2'h3;
	localparam logic [4:0] RTDT_VS_ZERO_WIDTH = 5'h10;
	localparam logic [4:0] RTDT_STEP_NORMAL = 5'h01;
	localparam logic [4:0] RTDT_STEP_VIDEO = 5'h02;

	// ----------------------------------------
	// Fixed screen format; totals are last count index, adjust is a line count
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] horizTotal;
		logic [7:0] horizDisplayed;
		logic [7:0] hsyncPosition;
		logic [7:0] syncWidths;
		logic [6:0] vertTotal;
		logic [4:0] vertTotalAdjust;
		logic [6:0] vertDisplayed;
		logic [6:0] vsyncPosition;
		logic [1:0] interlaceMode;
		logic [4:0] maxScanLine;
		logic [4:0] cursorStart;
		logic [4:0] cursorEnd;
	} rtdt_fmt_t;

	localparam rtdt_fmt_t RTDT_FMT0 = '{8'h63, 8'h50, 8'h52, 8'h3A, 7'h1A, 5'h02, 7'h18,
		7'h19, 2'h0, 5'h09, 5'h08, 5'h09};
	localparam rtdt_fmt_t RTDT_FMT1 = '{8'h4F, 8'h40, 8'h42, 8'h08, 7'h12, 5'h04, 7'h10,
		7'h11, 2'h1, 5'h0B, 5'h0A, 5'h0B};
endpackage : rtdt_pkg
`default_nettype wire

/* core/rtdt_sync2.sv */
// Two-stage synchroniser for pins arriving from outside the mclk domain
`default_nettype none
module rtdt_sync2 import rtdt_pkg::*; #(
	parameter int W = 1
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] held;
	} rtdt_sync_t;

	rtdt_sync_t q;
	rtdt_sync_t d;

	always_comb begin
		d = q;
		d.meta = din;
		d.held = q.meta;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign dout = q.held;
endmodule : rtdt_sync2
`default_nettype wire

/* core/rtdt_core.sv */
// Raster text display timing generator with write-only processor port
`default_nettype none

// How it works
// - Fourteen-bit refresh address output drives memory.
// - Five-bit scan-row address feeds character generator.
// - Cursor output high on cursor character, only on scan lines cursor start to cursor end.
// - Writes only with select low, write asserted.
// - Register select steers write: index or data.
// - Data bus is input only, never driven.
// - Write data captured on enable falling edge.
// - Counters advance once per character clock.
// - Format pin picks fixed parameter set.
// - Reset loads refresh address from start pair.
// - Reset homes counters, other outputs low.
// - Reset leaves index, start and cursor registers untouched.
// - Display resumes right after reset release.
// - Five-bit index; only start, cursor writable.
// - Deselected chip presents high impedance on data.
// - Horizontal total and displayed width from format.
// - Hsync width from low nibble, non-zero.
// - Vsync width high nibble, zero means sixteen.
// - Frame is rows plus adjust lines.
// - Vsync starts at programmed character row.
// - Three scan modes: normal, interlace, interlace video.
// - Max scan line sets scan-row wrap point.
// - Start address is six high, eight low.
// - Cursor address is six high, eight low.
module rtdt_core import rtdt_pkg::*; (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic charClk,
	input wire logic resetN,
	input wire logic csN,
	input wire logic regSelect,
	input wire logic writeN,
	input wire logic busEnable,
	input wire logic [RTDT_DATA_W-1:0] busData,
	input wire logic formatSetSelect,
	output logic [RTDT_ADDR_W-1:0] refreshAddr,
	output logic [RTDT_SCAN_W-1:0] scanRowAddr,
	output logic hsync,
	output logic vsync,
	output logic displayEnable,
	output logic cursor
);
	typedef struct packed {
		logic clkPrev;
		logic enPrev;
		logic [RTDT_IDX_W-1:0] index;
		logic [RTDT_HI_W-1:0] startHi;
		logic [RTDT_DATA_W-1:0] startLo;
		logic [RTDT_HI_W-1:0] cursorHi;
		logic [RTDT_DATA_W-1:0] cursorLo;
		logic [7:0] hCnt;
		logic [RTDT_SCAN_W-1:0] scan;
		logic [6:0] row;
		logic inAdjust;
		logic [4:0] adjCnt;
		logic [3:0] hsCnt;
		logic [4:0] vsCnt;
		logic vsHalf;
		logic field;
		logic [RTDT_ADDR_W-1:0] addr;
		logic [RTDT_ADDR_W-1:0] rowStart;
		logic hsync;
		logic vsync;
		logic de;
		logic cursor;
	} rtdt_state_t;

	rtdt_state_t q;
	rtdt_state_t d;

	// ----------------------------------------
	// Pin synchronisation
	// ----------------------------------------
	// Data is synchronised with the same latency as enable, so the
	// sample taken at the detected fall matches the bus state at the fall.
	logic [RTDT_PIN_W-1:0] pinRaw;
	logic [RTDT_PIN_W-1:0] pinS;
	logic clkS, rstS, csS, rsS, wrS, enS, fmtS;
	logic [RTDT_DATA_W-1:0] dataS;

	assign pinRaw = {charClk, resetN, csN, regSelect, writeN, busEnable, formatSetSelect, busData};

	rtdt_sync2 #(.W(RTDT_PIN_W)) pinSync (
		.mclk(mclk),
		.arst_n(arst_n),
		.din(pinRaw),
		.dout(pinS)
	);

	assign {clkS, rstS, csS, rsS, wrS, enS, fmtS, dataS} = pinS;

	// ----------------------------------------
	// Derived terms
	// ----------------------------------------
	rtdt_fmt_t fmt;
	logic tick, wrStrobe, lineEnd, rowDone, frameEnd, videoMode, syncIl;
	logic [RTDT_SCAN_W-1:0] step, baseScan;
	logic [RTDT_SCAN_W:0] scanSum;
	logic [RTDT_ADDR_W-1:0] startAddr, cursorAddr;
	logic [4:0] vsWidth;
	logic [RTDT_IDX_W-1:0] dataIdx;

	assign fmt = fmtS ? RTDT_FMT1 : RTDT_FMT0;
	assign tick = clkS && !q.clkPrev;
	assign wrStrobe = q.enPrev && !enS && !csS && !wrS;
	assign dataIdx = dataS[RTDT_IDX_W-1:0];
	assign startAddr = {q.startHi, q.startLo};
	assign cursorAddr = {q.cursorHi, q.cursorLo};
	assign videoMode = fmt.interlaceMode == RTDT_IL_VIDEO;
	assign syncIl = fmt.interlaceMode[0];
	assign step = videoMode ? RTDT_STEP_VIDEO : RTDT_STEP_NORMAL;
	assign baseScan = videoMode ? {{(RTDT_SCAN_W-1){1'b0}}, q.field} : '0;
	assign scanSum = {1'b0, q.scan} + {1'b0, step};
	assign rowDone = scanSum > {1'b0, fmt.maxScanLine};
	assign lineEnd = q.hCnt == fmt.horizTotal;
	assign vsWidth = (fmt.syncWidths[7:4] == 4'h0) ? RTDT_VS_ZERO_WIDTH
		: {1'b0, fmt.syncWidths[7:4]};

	// End of frame: last adjust line, or last row when no adjust lines
	always_comb begin
		frameEnd = 1'b0;
		if (q.inAdjust) begin
			frameEnd = ({1'b0, q.adjCnt} + 6'h01) >= {1'b0, fmt.vertTotalAdjust};
		end else if (rowDone && q.row == fmt.vertTotal) begin
			frameEnd = fmt.vertTotalAdjust == 5'h00;
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		d = q;
		d.clkPrev = clkS;
		d.enPrev = enS;

		// Registers keep their value under the reset pin
		if (wrStrobe) begin
			if (!rsS) begin
				d.index = dataIdx;
			end else begin
				case (q.index)
					RTDT_IDX_START_HI: d.startHi = dataS[RTDT_HI_W-1:0];
					RTDT_IDX_START_LO: d.startLo = dataS;
					RTDT_IDX_CURSOR_HI: d.cursorHi = dataS[RTDT_HI_W-1:0];
					RTDT_IDX_CURSOR_LO: d.cursorLo = dataS;
					default: ;
				endcase
			end
		end

		if (!rstS) begin
			// Home position; outputs low except the address
			d.hCnt = '0;
			d.scan = '0;
			d.row = '0;
			d.inAdjust = 1'b0;
			d.adjCnt = '0;
			d.hsCnt = '0;
			d.vsCnt = '0;
			d.vsHalf = 1'b0;
			d.field = 1'b0;
			d.addr = startAddr;
			d.rowStart = startAddr;
			d.hsync = 1'b0;
			d.vsync = 1'b0;
			d.de = 1'b0;
			d.cursor = 1'b0;
		end else if (tick) begin
			d.hCnt = lineEnd ? '0 : q.hCnt + 8'h01;

			if (lineEnd) begin
				if (frameEnd) begin
					d.row = '0;
					d.inAdjust = 1'b0;
					d.adjCnt = '0;
					d.field = syncIl ? !q.field : 1'b0;
					d.scan = (videoMode && !q.field) ? RTDT_SCAN_W'(1) : '0;
					d.addr = startAddr;
					d.rowStart = startAddr;
				end else if (q.inAdjust) begin
					d.adjCnt = q.adjCnt + 5'h01;
					d.scan = q.scan + 5'h01;
					d.addr = q.rowStart;
				end else if (rowDone) begin
					// Next row begins where this row's last character ended
					d.rowStart = q.rowStart + RTDT_ADDR_W'(fmt.horizDisplayed);
					d.addr = d.rowStart;
					d.scan = baseScan;
					if (q.row == fmt.vertTotal) begin
						d.inAdjust = 1'b1;
						d.scan = '0;
					end else begin
						d.row = q.row + 7'h01;
					end
				end else begin
					d.scan = scanSum[RTDT_SCAN_W-1:0];
					d.addr = q.rowStart;
				end

				// Vertical sync counted in lines
				if (!d.inAdjust && d.row == fmt.vsyncPosition && d.scan == baseScan
					&& !q.inAdjust && (rowDone || frameEnd)) begin
					d.vsCnt = vsWidth;
				end else if (q.vsCnt != 5'h00) begin
					d.vsCnt = q.vsCnt - 5'h01;
				end
			end else if (d.hCnt < fmt.horizDisplayed) begin
				d.addr = q.addr + RTDT_ADDR_W'(1);
			end

			// Odd interlaced field shifts vsync edges by half a line
			if (d.hCnt == {1'b0, fmt.horizTotal[7:1]}) begin
				d.vsHalf = d.vsCnt != 5'h00;
			end

			if (d.hCnt == fmt.hsyncPosition) begin
				d.hsCnt = fmt.syncWidths[3:0];
			end else if (q.hsCnt != 4'h0) begin
				d.hsCnt = q.hsCnt - 4'h1;
			end

			d.hsync = d.hsCnt != 4'h0;
			d.vsync = (syncIl && q.field) ? d.vsHalf : (d.vsCnt != 5'h00);
			d.de = d.hCnt < fmt.horizDisplayed && !d.inAdjust
				&& d.row < fmt.vertDisplayed;
			d.cursor = d.de && d.addr == cursorAddr && d.scan >= fmt.cursorStart
				&& d.scan <= fmt.cursorEnd;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// No data output exists: the bus pins are inputs only, so the
	// deselected chip never loads the processor bus.
	assign refreshAddr = q.addr;
	assign scanRowAddr = q.scan;
	assign hsync = q.hsync;
	assign vsync = q.vsync;
	assign displayEnable = q.de;
	assign cursor = q.cursor;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	// Reset pin behaviour
	resetAddr_a: assert property (!rstS |=> refreshAddr == $past(startAddr))
		else $error("refresh address not loaded from start pair in reset");
	resetOut_a: assert property (!rstS |=> !hsync && !vsync
		&& !displayEnable && !cursor && scanRowAddr == '0 && q.hCnt == '0)
		else $error("outputs not homed during reset");
	regKeep_a: assert property (!rstS && !wrStrobe |=> $stable(q.index)
		&& $stable(startAddr) && $stable(cursorAddr))
		else $error("register changed by reset");

	// Write path: each byte lands one edge after the detected enable fall
	indexWrite_a: assert property (wrStrobe && !rsS |=> q.index == $past(dataIdx))
		else $error("index write lost");
	noStrobe_a: assert property (!wrStrobe |=> $stable(startAddr) && $stable(cursorAddr))
		else $error("register written without strobe");
	startHiWrite_a: assert property (wrStrobe && rsS && q.index == RTDT_IDX_START_HI
		|=> q.startHi == $past(dataS[RTDT_HI_W-1:0]))
		else $error("start address high byte lost");
	startLoWrite_a: assert property (wrStrobe && rsS && q.index == RTDT_IDX_START_LO
		|=> q.startLo == $past(dataS))
		else $error("start address low byte lost");
	cursorHiWrite_a: assert property (wrStrobe && rsS && q.index == RTDT_IDX_CURSOR_HI
		|=> q.cursorHi == $past(dataS[RTDT_HI_W-1:0]))
		else $error("cursor address high byte lost");
	cursorLoWrite_a: assert property (wrStrobe && rsS && q.index == RTDT_IDX_CURSOR_LO
		|=> q.cursorLo == $past(dataS))
		else $error("cursor address low byte lost");

	// Character timing: nothing moves between ticks
	tickHold_a: assert property (rstS && !tick |=> $stable(q.hCnt) && $stable(refreshAddr))
		else $error("counter moved without character clock");
	outHold_a: assert property (rstS && !tick |=> $stable(hsync) && $stable(vsync)
		&& $stable(displayEnable) && $stable(cursor) && $stable(scanRowAddr))
		else $error("output moved without character clock");
	addrStep_a: assert property (rstS && tick && q.hCnt < fmt.horizDisplayed - 8'h01
		|=> refreshAddr == $past(refreshAddr) + RTDT_ADDR_W'(1))
		else $error("refresh address did not step");

	// Line and row ends of the address and scan counters
	lineStep_a: assert property (rstS && tick && lineEnd && !rowDone && !q.inAdjust
		|=> refreshAddr == $past(q.rowStart) && scanRowAddr == $past(q.scan) + $past(step))
		else $error("line did not restart at row start");
	rowStep_a: assert property (rstS && tick && lineEnd && rowDone && !q.inAdjust
		&& q.row != fmt.vertTotal |=> q.row == $past(q.row) + 7'h01
		&& refreshAddr == $past(q.rowStart) + RTDT_ADDR_W'($past(fmt.horizDisplayed))
		&& scanRowAddr == $past(baseScan))
		else $error("row did not advance by the displayed width");

	// Sync edges and the active area
	hsyncPos_a: assert property ($rose(hsync) |-> q.hCnt == fmt.hsyncPosition)
		else $error("hsync rose away from its position");
	vsyncRow_a: assert property ($rose(vsync) && !syncIl |-> q.row == fmt.vsyncPosition)
		else $error("vsync rose on wrong row");
	deRange_a: assert property (displayEnable |-> q.hCnt < fmt.horizDisplayed
		&& q.row < fmt.vertDisplayed)
		else $error("display enable outside active area");
	scanWrap_a: assert property (!q.inAdjust |-> q.scan <= fmt.maxScanLine)
		else $error("scan row past maximum");

	// Cursor is decoded at the tick, so compare against what stood then
	cursorMatch_a: assert property (cursor |-> displayEnable && refreshAddr == cursorAddr)
		else $error("cursor asserted off the cursor character");
	cursorLines_a: assert property (rstS && tick ##1 cursor
		|-> scanRowAddr >= $past(fmt.cursorStart) && scanRowAddr <= $past(fmt.cursorEnd))
		else $error("cursor asserted outside its scan lines");
	cursorHit_a: assert property (rstS && tick ##1 displayEnable
		&& refreshAddr == $past(cursorAddr) && scanRowAddr >= $past(fmt.cursorStart)
		&& scanRowAddr <= $past(fmt.cursorEnd) |-> cursor)
		else $error("cursor missing on the cursor character");

	// ----------------------------------------
	// Cover points
	// ----------------------------------------
	cursorSeen_c: cover property (rstS ##1 cursor);
	vsyncSeen_c: cover property ($rose(vsync));
	startWrite_c: cover property (wrStrobe && rsS && q.index == RTDT_IDX_START_LO);
	hsyncSeen_c: cover property ($rose(hsync));
	rowWrap_c: cover property (rstS && tick && lineEnd && rowDone);
endmodule : rtdt_core
`default_nettype wire

/* dv/rtdt_crt_model.sv */
// Character clock source standing in for the dot counter and monitor side
`default_nettype none
module rtdt_crt_model (
	input wire logic mclk,
	input wire logic arst_n,
	output logic charClk,
	output logic sampleNow
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] phase_q;

	// Three high, three low: each phase outlasts the one mclk cycle the core needs to see a level
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			phase_q <= 3'h0;
		end else begin
			phase_q <= (phase_q == 3'h5) ? 3'h0 : phase_q + 3'h1;
		end
	end
	assign charClk = (phase_q < 3'h3);
	// Late in the period, after the previous tick has settled the outputs
	assign sampleNow = (phase_q == 3'h5);
endmodule : rtdt_crt_model
`default_nettype wire

/* dv/rtdt_core_test.sv */
// Self-checking bench for the raster text display timing core
`default_nettype none
module rtdt_core_test import rtdt_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0, arst_n = 1'b0, resetN = 1'b0, csN = 1'b1, regSelect = 1'b0;
	logic writeN = 1'b1, busEnable = 1'b1, formatSetSelect = 1'b0;
	logic [RTDT_DATA_W-1:0] busData = 8'hA5;
	logic [RTDT_ADDR_W-1:0] refreshAddr;
	logic [RTDT_SCAN_W-1:0] scanRowAddr;
	logic hsync, vsync, displayEnable, cursor, charClk, sampleNow;
	int fail_count = 0, num_checks = 0, cycles = 0;
	int nDe, nHs, nCur;
	typedef struct packed {
		logic fmt;
		logic [7:0] hi;
		logic [7:0] lo;
		logic [13:0] addr;
		logic [7:0] line;
		logic [7:0] de;
		logic [3:0] hs;
	} rtdt_row_t;
	rtdt_row_t rows [3] = '{
		'{1'b0, 8'h12, 8'hAB, 14'h12AB, 8'h64, 8'h50, 4'hA},
		'{1'b0, 8'hFF, 8'h34, 14'h3F34, 8'h64, 8'h50, 4'hA},
		'{1'b1, 8'hC0, 8'h01, 14'h0001, 8'h50, 8'h40, 4'h8}
	};

	rtdt_core dut (.mclk(mclk), .arst_n(arst_n), .charClk(charClk), .resetN(resetN), .csN(csN),
		.regSelect(regSelect), .writeN(writeN), .busEnable(busEnable), .busData(busData),
		.formatSetSelect(formatSetSelect), .refreshAddr(refreshAddr), .scanRowAddr(scanRowAddr),
		.hsync(hsync), .vsync(vsync), .displayEnable(displayEnable), .cursor(cursor));
	rtdt_crt_model crt (.mclk(mclk), .arst_n(arst_n), .charClk(charClk), .sampleNow(sampleNow));

	always #20 mclk = ~mclk;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic rs, input logic [7:0] d, input logic cs = 1'b0,
		input logic w = 1'b0);
		@(posedge mclk) #1;
		csN = cs;
		writeN = w;
		regSelect = rs;
		busData = d;
		repeat (3) @(posedge mclk);
		#1 busEnable = 1'b0;
		repeat (3) @(posedge mclk);
		#1 busEnable = 1'b1;
		csN = 1'b1;
		writeN = 1'b1;
		// Released lines must not keep the last value
		busData = ~d;
	endtask : wr

	task automatic load(input logic [4:0] idx, input logic [7:0] d);
		wr(1'b0, {3'h0, idx});
		wr(1'b1, d);
	endtask : load

	task automatic tick();
		@(posedge mclk iff sampleNow) #1;
	endtask : tick

	// Mid-period change so the first tick after release is never split by the synchroniser;
	// ends on the sample point just before the first tick that sees the new level
	task automatic setReset(input logic v);
		tick();
		repeat (3) @(posedge mclk);
		#1 resetN = v;
		tick();
	endtask : setReset

	task automatic run(input int n);
		nDe = 0;
		nHs = 0;
		nCur = 0;
		repeat (n) begin
			tick();
			if (displayEnable === 1'b1) nDe++;
			if (hsync === 1'b1) nHs++;
			if (cursor === 1'b1) nCur++;
		end
	endtask : run

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			tally_and_finish();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge mclk);
		#1 arst_n = 1'b1;
		repeat (4) tick();
		check(refreshAddr, 14'h0000);
		check({hsync, vsync, displayEnable, cursor, scanRowAddr}, 9'h000);
		$display("reset test done");
		foreach (rows[i]) begin
			formatSetSelect = rows[i].fmt;
			load(RTDT_IDX_START_HI, rows[i].hi);
			load(RTDT_IDX_START_LO, rows[i].lo);
			repeat (2) tick();
			check(refreshAddr, rows[i].addr);
			check({hsync, vsync, displayEnable, cursor, scanRowAddr}, 9'h000);
			setReset(1'b1);
			run(rows[i].line);
			check(16'(nDe), rows[i].de);
			check(16'(nHs), rows[i].hs);
			check(refreshAddr, rows[i].addr);
			check(scanRowAddr, 5'h01);
			setReset(1'b0);
			$display("format row %0d done", i);
		end
		// Start near the top of memory so row one wraps to the bottom
		formatSetSelect = 1'b0;
		load(RTDT_IDX_START_HI, 8'h3F);
		load(RTDT_IDX_START_LO, 8'hF0);
		load(5'h01, 8'h00);
		load(RTDT_IDX_CURSOR_HI, 8'h3F);
		load(RTDT_IDX_CURSOR_LO, 8'hF5);
		wr(1'b0, 8'h0C, 1'b1, 1'b0);
		wr(1'b1, 8'h00, 1'b0, 1'b1);
		wr(1'b1, 8'h00, 1'b1, 1'b0);
		wr(1'b1, 8'hF5);
		setReset(1'b1);
		setReset(1'b0);
		repeat (2) tick();
		check(refreshAddr, 14'h3FF0);
		setReset(1'b1);
		run(1);
		check(refreshAddr, 14'h3FF1);
		check(displayEnable, 1'b1);
		run(999);
		check(16'(nCur), 16'h0002);
		check(refreshAddr, 14'h0040);
		check(scanRowAddr, 5'h00);
		$display("cursor and wrap test done");
		tally_and_finish();
	end
endmodule : rtdt_core_test
`default_nettype wire
